/* File: sim/quad_dac_chk.sv */
// Checker for the serial link pins between host end and device end.
// Assumes the bench clock and reset, and the link pins as inputs.
`timescale 1ns/1ps
module quad_dac_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Link pins
   input wire logic serialClk,
   input wire logic serialData,
   input wire logic frameSelN,
   input wire logic portDisable,
   input wire logic asyncLoadStrobe
);
   logic       clkPrev_r;
   logic [4:0] fallCnt_r;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Counts serial clock falls inside the current frame
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clkPrev_r <= 1'b0;
         fallCnt_r <= 5'h00;
      end else begin
         clkPrev_r <= serialClk;
         if (frameSelN)
            fallCnt_r <= 5'h00;
         else if (clkPrev_r && !serialClk)
            fallCnt_r <= fallCnt_r + 5'h01;
      end
   end

   chk_idle_clk_low: assert property (frameSelN |-> !serialClk)
      else $error("clock high outside frame");
   chk_first_rise: assert property ($fell(frameSelN) |->
      !serialClk [*3] ##[1:2] serialClk) else $error("first rise late");
   chk_data_at_fall: assert property ($fell(serialClk) |->
      $stable(serialData)) else $error("data moved at fall");
   chk_high_half: assert property ($rose(serialClk) |->
      serialClk [*4] ##1 !serialClk) else $error("high half wrong");
   chk_low_half: assert property ($fell(serialClk) &&
      fallCnt_r < 5'h17 |-> !serialClk [*4] ##1 serialClk)
      else $error("low half wrong");
   chk_fall_count: assert property ($rose(frameSelN) |->
      fallCnt_r == 5'h18) else $error("frame not 24 bits");
   chk_no_extra_clk: assert property (fallCnt_r == 5'h18 |->
      !serialClk) else $error("clock after 24th bit");
   chk_async_idle: assert property ($rose(asyncLoadStrobe) |->
      frameSelN) else $error("async load inside frame");

   cover property ($rose(frameSelN));
   cover property ($rose(asyncLoadStrobe));
   cover property (portDisable && $fell(frameSelN));
endmodule

/* File: sim/quad_dac_serial_update_control_tb_top.sv */
// Bench: APB drives the host end, which talks to the device end.
// Assumes the design under verilog/ and a 10 MHz core clock.
`timescale 1ns/1ps
`include "quad_dac_cfg.svh"
module quad_dac_serial_update_control_tb_top;
   import quad_dac_pkg::*;
   logic        core_clk, rst, psel, penable, pwrite, pready;
   logic        pslverr, lastErr, sclkPrev;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] rnd = 32'h0000001D;
   logic [1:0]  devAddr;
   logic [23:0] wireW;
   logic [17:0] mBuf [4];
   logic [17:0] mOut [4];
   chanBank_t   chanOut, chanBuf;
   int          errTotal, comparisons, sent;
   logic        frameDone, frameAbort;
   int          doneCnt, abortCnt;

   quad_dac_if link ();
   quad_dac_host i_quad_dac_host (.core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   quad_dac_dev i_quad_dac_dev (.core_clk(core_clk), .rst(rst),
      .link(link), .devAddr(devAddr), .chanOut(chanOut),
      .chanBuf(chanBuf), .frameDone(frameDone),
      .frameAbort(frameAbort));
   quad_dac_chk i_quad_dac_chk (.core_clk(core_clk), .rst(rst),
      .serialClk(link.serialClk), .serialData(link.serialData),
      .frameSelN(link.frameSelN), .portDisable(link.portDisable),
      .asyncLoadStrobe(link.asyncLoadStrobe));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Counts completed and discarded frames seen by the device
   always @(posedge core_clk) begin
      if (frameDone === 1'b1)
         doneCnt++;
      if (frameAbort === 1'b1)
         abortCnt++;
   end

   // Shifts in what crosses the wire, one bit per serial clock fall
   always @(posedge core_clk) begin
      sclkPrev <= link.serialClk;
      if (link.frameSelN === 1'b0 && sclkPrev && !link.serialClk)
         wireW <= {wireW[22:0], link.serialData};
   end

   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction

   task automatic printVerdict();
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errTotal++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) begin
         errTotal++;
         printVerdict();
      end
      q = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reference of the channel buffers and outputs
   task automatic model(input logic [23:0] c);
      logic [17:0] v;
      int          ch;
      ch = c[18:17];
      v = {2'h0, c[15:0]};
      if (c[16])
         v = {(c[15:14] == 2'h0) ? 2'h3 : c[15:14], 16'h0000};
      if (c[23:22] == devAddr && link.portDisable === 1'b0) begin
         mBuf[ch] = v;
         if (c[20])
            mOut[ch] = v;
         if (c[21])
            mOut = mBuf;
      end
   endtask

   task automatic cmpAll();
      for (int i = 0; i < 4; i++) begin
         chk(32'(chanBuf[i]), 32'(mBuf[i]));
         chk(32'(chanOut[i]), 32'(mOut[i]));
      end
   endtask

   task automatic send(input logic [23:0] c);
      logic [31:0] q;
      int          n;
      apb(1'b1, `REG_CMD, {8'h00, c}, q);
      n = 0;
      do begin
         apb(1'b0, `REG_STAT, 32'h0, q);
         n++;
      end while (q[`STAT_BUSY] !== 1'b0 && n < 200);
      if (n == 200) begin
         errTotal++;
         printVerdict();
      end
      sent++;
      chk(32'(q[31:16]), 32'(sent));
      chk(32'(wireW), 32'(c));
      model(c);
      cmpAll();
   endtask

   initial begin
      logic [31:0] q;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      devAddr = 2'h2;
      for (int i = 0; i < 4; i++) begin
         mBuf[i] = 18'h0;
         mOut[i] = 18'h0;
      end
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      cmpAll();
      $display("test reset done");
      for (int i = 0; i < 32; i++) begin
         q = xs();
         send({devAddr, i[1:0], q[31], i[3:2], i[4], q[15:0]});
      end
      $display("test load modes done");
      for (int i = 0; i < 16; i++) begin
         q = xs();
         send(q[23:0]);
      end
      $display("test random done");
      send({devAddr, 6'h02, 16'h5A5A});
      apb(1'b1, `REG_CTRL, 32'h2, q);
      repeat (6) @(posedge core_clk);
      mOut = mBuf;
      cmpAll();
      $display("test async load done");
      apb(1'b1, `REG_CTRL, 32'h1, q);
      repeat (4) @(posedge core_clk);
      send({devAddr, 6'h20, 16'hABCD});
      apb(1'b1, `REG_CTRL, 32'h0, q);
      $display("test port disable done");
      apb(1'b0, 8'h0C, 32'h0, q);
      chk(q, 32'h0);
      chk(32'(lastErr), 32'h1);
      $display("test unmapped done");
      // Every frame but the one sent while the port was off completes
      chk(32'(doneCnt), 32'(sent - 1));
      chk(32'(abortCnt), 32'h0);
      $display("test frame events done");
      printVerdict();
   end
endmodule

/* File: verilog/quad_dac_cfg.svh */
// Constants for the quad converter serial update control: command word
// layout, power-down codes, host register map and link timing.
// Assumes inclusion by bare name from design files under verilog/.
`ifndef QUAD_DAC_CFG_SVH
`define QUAD_DAC_CFG_SVH

// Command word, 24 bits, first bit on the wire is bit 23
`define CMD_BITS        24
`define CMD_LAST_BIT    5'h17
`define ADDR_HI_POS     23
`define ADDR_LO_POS     22
`define LOAD_HI_POS     21
`define LOAD_LO_POS     20
`define UNUSED_POS      19
`define CH_SEL_HI_POS   18
`define CH_SEL_LO_POS   17
`define PD_FLAG_POS     16
`define PD_MODE_HI_POS  15
`define PD_MODE_LO_POS  14
`define DATA_HI_POS     15

// Power-down state kept beside each 16-bit code
`define PD_NORMAL       2'h0
`define PD_1K           2'h1
`define PD_100K         2'h2
`define PD_HIZ          2'h3
`define CODE_RST        16'h0000

// Host register map, one aligned word each
`define REG_CMD         8'h00
`define REG_CTRL        8'h04
`define REG_STAT        8'h08
`define CTRL_PORT_OFF   0
`define CTRL_ASYNC_LD   1
`define CTRL_RST        2'h0
`define STAT_BUSY       0
`define STAT_CNT_LO     16

// Link timing
`define CORE_PERIOD_NS  100
`define SCLK_PERIOD_NS  800
`define HALF_SCLK_CYC   ((`SCLK_PERIOD_NS) / (2 * (`CORE_PERIOD_NS)))

`endif

/* File: verilog/quad_dac_dev.sv */
// Device end: serial command receiver with double-buffered channels.
// Assumes link pins come from another clock domain and are slow
// against core_clk (serial clock period at least eight core cycles).
//
// Behaviour
// [R1] Upper load bit loads all outputs at 24th
// [R2] Frame loads happen on 24th falling clock
// [R3] Host keeps async load low if unused
// [R4] Async load rising edge copies all buffers
// [R5] Host fills buffers before async load
// [R6] Unchanged buffer keeps output unchanged on load
// [R7] Port disable high ignores serial activity
// [R8] Load bits 00 write buffer only
// [R9] Power-down 01 is 1k, 10 is 100k
// [R10] Power-down 11 gives high impedance
// [R11] Load bits 10 write then load all
// [R12] Load bits 01 write and load one channel
// [R13] Channel select 00..11 picks A..D
// [R14] First bit received is the MSB
// [R15] Host keeps frame low for three bytes
// [R16] Host idles clock low, data valid falling
// [R17] Respond only when address bits match
// [R18] Early frame rise discards the partial frame
// [R19] Reset clears all outputs to zero
// [R20] Normal data load leaves power-down
// [R21] Power-down command ignores low data bits
//
// Design decisions made here: the placing of the registers and the three-stage filter on the link pins.
`timescale 1ns/1ps
`include "quad_dac_cfg.svh"
module quad_dac_dev (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Link from the host
   quad_dac_if.dev          link,
   // Address strap
   input  wire logic [1:0]  devAddr,
   // Channel state
   output quad_dac_pkg::chanBank_t chanOut,
   output quad_dac_pkg::chanBank_t chanBuf,
   // Frame events
   output logic             frameDone,
   output logic             frameAbort
);
   import quad_dac_pkg::*;

   localparam int Sck = 0;
   localparam int Din = 1;
   localparam int Fsn = 2;
   localparam int Dis = 3;
   localparam int Ald = 4;

   typedef struct packed {
      logic [4:0][2:0] syn;
      logic [4:0]      lvl;
      logic            active;
      logic [4:0]      cnt;
      logic [23:0]     sh;
      chanBank_t       buffer;
      chanBank_t       outReg;
      logic            done;
      logic            abort;
   } dev_t;

   dev_t state_r;
   dev_t state_nxt;

   logic [4:0]  pinIn;
   logic [4:0]  newLvl;
   logic        sclkFall;
   logic        syncFall;
   logic        syncRise;
   logic        loadRise;
   logic [23:0] word;
   logic [1:0]  sel;
   chanWord_t   entry;

   assign pinIn = {link.asyncLoadStrobe, link.portDisable,
                   link.frameSelN, link.serialData, link.serialClk};

   // Filtered levels: the third stage confirms the second
   always_comb begin
      newLvl = state_r.lvl;
      for (int i = 0; i < 5; i++) begin
         if (state_r.syn[i][1] == state_r.syn[i][2])
            newLvl[i] = state_r.syn[i][2];
      end
   end

   assign sclkFall = state_r.lvl[Sck] & ~newLvl[Sck];
   assign syncFall = state_r.lvl[Fsn] & ~newLvl[Fsn];
   assign syncRise = ~state_r.lvl[Fsn] & newLvl[Fsn];
   assign loadRise = ~state_r.lvl[Ald] & newLvl[Ald];

   // Bit on the wire is shifted in at the low end, so bit 23 is first
   assign word = {state_r.sh[22:0], newLvl[Din]}; // R14
   assign sel  = word[`CH_SEL_HI_POS:`CH_SEL_LO_POS]; // R13

   // Power-down entry keeps only the mode bits; 00 also means Hi-Z
   always_comb begin
      entry.pd   = `PD_NORMAL; // R20
      entry.code = word[`DATA_HI_POS:0];
      if (word[`PD_FLAG_POS]) begin
         entry.code = `CODE_RST; // R21
         entry.pd   = word[`PD_MODE_HI_POS:`PD_MODE_LO_POS]; // R9
         if (entry.pd == `PD_NORMAL)
            entry.pd = `PD_HIZ; // R10
      end
   end

   always_comb begin
      state_nxt       = state_r;
      state_nxt.done  = 1'b0;
      state_nxt.abort = 1'b0;
      state_nxt.lvl   = newLvl;
      for (int i = 0; i < 5; i++) begin
         state_nxt.syn[i] = {state_r.syn[i][1:0], pinIn[i]};
      end

      if (newLvl[Dis]) begin
         // Shared port: frames seen while disabled are dropped whole
         state_nxt.active = 1'b0; // R7
         state_nxt.cnt    = 5'h0;
         state_nxt.sh     = 24'h0;
      end else if (syncFall) begin
         state_nxt.active = 1'b1;
         state_nxt.cnt    = 5'h0;
         state_nxt.sh     = 24'h0;
      end else if (syncRise && state_r.active) begin
         state_nxt.active = 1'b0; // R18
         state_nxt.cnt    = 5'h0;
         state_nxt.sh     = 24'h0;
         state_nxt.abort  = 1'b1;
      end else if (state_r.active && sclkFall) begin
         state_nxt.sh  = word;
         state_nxt.cnt = state_r.cnt + 5'h1;
         if (state_r.cnt == `CMD_LAST_BIT) begin
            // Further clocks in this frame are ignored
            state_nxt.active = 1'b0; // R2
            state_nxt.done   = 1'b1;
            if (word[`ADDR_HI_POS:`ADDR_LO_POS] == devAddr) begin // R17
               state_nxt.buffer[sel] = entry; // R8
               if (word[`LOAD_HI_POS]) begin
                  state_nxt.outReg = state_nxt.buffer; // R1 R11
               end else if (word[`LOAD_LO_POS]) begin
                  state_nxt.outReg[sel] = entry; // R12
               end
            end
         end
      end

      // After any frame write, so a same-cycle write is included
      if (loadRise)
         state_nxt.outReg = state_nxt.buffer; // R4 R6
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r     <= '0; // R19
         // Idle levels: frame select high, every other pin low, so no
         // false load or clock edge follows reset
         state_r.syn      <= '0;
         state_r.syn[Fsn] <= 3'h7;
         state_r.lvl      <= 5'h04;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign chanOut    = state_r.outReg;
   assign chanBuf    = state_r.buffer;
   assign frameDone  = state_r.done;
   assign frameAbort = state_r.abort;
endmodule

/* File: verilog/quad_dac_host.sv */
// Host end: APB slave registers drive a 24-bit serial frame sender and
// the load and enable pins.
// Assumes a zero-wait APB master on core_clk and the device on the link.
`timescale 1ns/1ps
`include "quad_dac_cfg.svh"
module quad_dac_host (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Link to the converter
   quad_dac_if.host         link
);
   import quad_dac_pkg::*;

   localparam logic [3:0] HalfLast = 4'(`HALF_SCLK_CYC - 1);

   typedef enum logic [2:0] {IDLE, LEAD, HIGH, LOW, TRAIL, GAP} hstate_t;

   typedef struct packed {
      hstate_t     st;
      logic [3:0]  div;
      logic [4:0]  bitCnt;
      logic [23:0] sh;
      logic        sclk;
      logic        sdata;
      logic        syncN;
      logic [1:0]  ctrl;
      logic [15:0] sent;
      logic [31:0] rdata;
   } host_t;

   host_t state_r;
   host_t state_nxt;

   logic access;
   logic mapped;
   logic busy;
   logic tick;

   assign busy   = state_r.st != IDLE;
   assign access = psel & penable;
   assign mapped = paddr == `REG_CMD || paddr == `REG_CTRL
                   || paddr == `REG_STAT;
   assign tick   = state_r.div == HalfLast;
   // Zero wait states; a command written while a frame runs is refused
   assign pready  = 1'b1;
   assign pslverr = access & (~mapped
                    | (pwrite & paddr == `REG_CMD & busy));

   always_comb begin
      state_nxt = state_r;
      // Read data is captured in the setup cycle
      if (psel & ~penable) begin
         unique case (paddr)
            `REG_CTRL: state_nxt.rdata = {30'h0, state_r.ctrl};
            `REG_STAT: begin
               state_nxt.rdata = 32'h0;
               state_nxt.rdata[`STAT_BUSY] = busy;
               state_nxt.rdata[31:`STAT_CNT_LO] = state_r.sent;
            end
            default:   state_nxt.rdata = 32'h0;
         endcase
      end
      if (state_r.st == IDLE)
         state_nxt.div = 4'h0;
      else
         state_nxt.div = tick ? 4'h0 : state_r.div + 4'h1;
      unique case (state_r.st)
         IDLE: ;
         LEAD, LOW: if (tick) begin
            if (state_r.bitCnt == 5'(`CMD_BITS)) begin
               state_nxt.st = TRAIL;
            end else begin
               // Data changes on the rising edge, device takes it falling
               state_nxt.st    = HIGH;
               state_nxt.sclk  = 1'b1;
               state_nxt.sdata = state_r.sh[23]; // R14 R16
               state_nxt.sh    = {state_r.sh[22:0], 1'b0};
            end
         end
         HIGH: if (tick) begin
            state_nxt.st     = LOW;
            state_nxt.sclk   = 1'b0; // R16
            state_nxt.bitCnt = state_r.bitCnt + 5'h1;
         end
         TRAIL: if (tick) begin
            // Frame select held low over all 24 bits, raised after
            state_nxt.st    = GAP;
            state_nxt.syncN = 1'b1; // R15
         end
         GAP: if (tick) begin
            state_nxt.st   = IDLE;
            state_nxt.sent = state_r.sent + 16'h1;
         end
      endcase
      if (access & pwrite) begin
         if (paddr == `REG_CMD && !busy) begin
            state_nxt.st     = LEAD;
            state_nxt.div    = 4'h0;
            state_nxt.bitCnt = 5'h0;
            state_nxt.sh     = pwdata[23:0];
            state_nxt.syncN  = 1'b0;
         end
         if (paddr == `REG_CTRL)
            state_nxt.ctrl = pwdata[1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r       <= '0;
         state_r.st    <= IDLE;
         state_r.syncN <= 1'b1;
         state_r.ctrl  <= `CTRL_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign prdata               = state_r.rdata;
   assign link.serialClk       = state_r.sclk;
   assign link.serialData      = state_r.sdata;
   assign link.frameSelN       = state_r.syncN;
   assign link.portDisable     = state_r.ctrl[`CTRL_PORT_OFF]; // R7
   // Software keeps this low when only frame loads are used
   assign link.asyncLoadStrobe = state_r.ctrl[`CTRL_ASYNC_LD]; // R3 R5
endmodule

/* File: verilog/quad_dac_if.sv */
// Three-wire serial link plus load and enable pins between host and
// converter. All pins are single-driver outputs of the host.
`timescale 1ns/1ps
interface quad_dac_if;
   logic serialClk;
   logic serialData;
   logic frameSelN;
   logic portDisable;
   logic asyncLoadStrobe;

   modport dev (
      input serialClk,
      input serialData,
      input frameSelN,
      input portDisable,
      input asyncLoadStrobe
   );
   modport host (
      output serialClk,
      output serialData,
      output frameSelN,
      output portDisable,
      output asyncLoadStrobe
   );
endinterface

/* File: verilog/quad_dac_pkg.sv */
// Types shared by both ends of the quad converter serial link.
// Assumes quad_dac_cfg.svh for the numeric constants.
package quad_dac_pkg;
   typedef logic [15:0] code_t;
   typedef logic [1:0]  pdMode_t;
   typedef struct packed {
      pdMode_t pd;
      code_t   code;
   } chanWord_t;
   typedef chanWord_t [3:0] chanBank_t;
endpackage
